// file: adc_control_logic.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module adc_control_logic (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [adc_control_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                      pwdata,
    output logic [31:0]                           prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic                             ext_int_en,
    input  wire adc_control_pkg::conv_rsp_s       conv_rsp,
    output var adc_control_pkg::conv_cmd_s        conv_cmd,
    output logic [7:0]                            pin_analog,
    output var adc_control_pkg::pin_fn_e          pin0_fn,
    output logic                                  reference_pin_analog,
    output logic                                  irq
);
    import adc_control_pkg::*;

    ctl_state_s q;
    ctl_state_s d;
    logic [5:0] idx;
    logic       hit;
    logic       wr;
    logic       go_set;
    logic       hw_go_clr;
    logic       start_req;
    logic       tad_tick;
    logic       sample_busy;
    logic [7:0] rd_byte;

    ////////////////////////////////////////////////////////////////////////
    // Address decode and read multiplexer.
    assign idx = paddr[7:2];

    always_comb begin
        hit = (paddr[1:0] == 2'h0);
        rd_byte = 8'h00;
        case (idx)
            IDX_PIN_EN:   rd_byte = q.pin_en;
            IDX_CTL:      rd_byte = q.ctl;
            IDX_CAL: begin
                rd_byte[CAL_HALF] = q.half_sup;
            end
            IDX_RES_HIGH: rd_byte = q.result[11:4];
            IDX_RES_LOW: begin
                rd_byte[3:0] = q.result[3:0];
                rd_byte[LOW_REF_LSB+:2] = q.ref_level;
            end
            IDX_TRIM:     rd_byte[TRIM_LSB+:2] = q.trim;
            IDX_INT_STAT: rd_byte[INT_DONE] = q.done_flag;
            IDX_INT_MASK: rd_byte[INT_DONE] = q.done_mask;
            default:      hit = 1'b0;
        endcase
    end

    assign wr = psel && penable && pwrite && hit;
    assign go_set = wr && idx == IDX_CTL && pwdata[CTL_GO];
    assign start_req = q.state == ST_IDLE && q.ctl[CTL_GO] && q.ctl[CTL_PWR];

    ////////////////////////////////////////////////////////////////////////
    // Sample timing and converter clock.
    adc_tad_gen u_tad_gen (
        .pclk        (pclk),
        .presetn     (presetn),
        .run         (q.ctl[CTL_PWR]),
        .rate        (q.ctl[CTL_RATE_LSB+:2]),
        .trim        (q.trim),
        .start       (start_req),
        .tad_tick    (tad_tick),
        .sample_busy (sample_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register writes and the conversion sequencer.
    always_comb begin
        d = q;
        d.conv_start = 1'b0;
        hw_go_clr = 1'b0;
        if (psel && !penable) begin
            d.prdata = {24'h000000, rd_byte};
        end
        if (wr) begin
            case (idx)
                IDX_PIN_EN: d.pin_en = pwdata[7:0];
                IDX_CTL: begin
                    d.ctl = pwdata[7:0];
                    d.ctl[CTL_GO] = q.ctl[CTL_GO] | pwdata[CTL_GO];
                end
                IDX_CAL:      d.half_sup = pwdata[CAL_HALF];
                IDX_RES_LOW:  d.ref_level = pwdata[LOW_REF_LSB+:2];
                IDX_TRIM:     d.trim = pwdata[TRIM_LSB+:2];
                IDX_INT_STAT: begin
                    d.done_flag = q.done_flag & ~pwdata[INT_DONE];
                end
                IDX_INT_MASK: d.done_mask = pwdata[INT_DONE];
                default: begin
                end
            endcase
        end
        case (q.state)
            ST_IDLE: begin
                if (start_req) begin
                    d.cap_channel = q.ctl[CTL_CHAN_LSB+:3];
                    d.cap_ref_ext = q.ctl[CTL_REF_SRC];
                    d.cap_ref_level = q.ref_level;
                    d.cap_half = q.half_sup;
                    d.state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (!q.ctl[CTL_PWR]) begin
                    hw_go_clr = 1'b1;
                    d.ctl[CTL_GO] = go_set;
                    d.state = ST_IDLE;
                end else if (!sample_busy) begin
                    d.conv_start = 1'b1;
                    d.state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (!q.ctl[CTL_PWR]) begin
                    hw_go_clr = 1'b1;
                    d.ctl[CTL_GO] = go_set;
                    d.state = ST_IDLE;
                end else if (conv_rsp.done) begin
                    d.result = conv_rsp.result;
                    hw_go_clr = 1'b1;
                    d.ctl[CTL_GO] = go_set;
                    d.done_flag = 1'b1;
                    d.state = ST_IDLE;
                end
            end
            default: d.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= CTL_STATE_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign irq = q.done_flag && q.done_mask;

    assign pin_analog = q.pin_en;
    assign reference_pin_analog = q.ctl[CTL_REF_SRC];

    always_comb begin
        if (ext_int_en) begin
            pin0_fn = PIN_INT;
        end else if (q.pin_en[0]) begin
            pin0_fn = PIN_ANALOG;
        end else begin
            pin0_fn = PIN_DIGITAL;
        end
    end

    always_comb begin
        conv_cmd.power_on = q.ctl[CTL_PWR];
        conv_cmd.start = q.conv_start;
        conv_cmd.sampling = q.state == ST_SAMPLE;
        conv_cmd.ref_external = q.cap_ref_ext;
        conv_cmd.ref_level = q.cap_ref_level;
        conv_cmd.half_supply = q.cap_half;
        conv_cmd.channel = q.cap_channel;
        conv_cmd.tad_tick = tad_tick;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_go_held;
        @(posedge pclk) disable iff (!presetn)
        q.ctl[CTL_GO] && !hw_go_clr |=> q.ctl[CTL_GO];
    endproperty
    a_go_held: assert property (p_go_held)
        else $error("Run bit dropped without a hardware clear.");

    property p_done_effects;
        @(posedge pclk) disable iff (!presetn)
        q.state == ST_CONVERT && q.ctl[CTL_PWR] && conv_rsp.done && !go_set
            |=> !q.ctl[CTL_GO] && q.done_flag
                && q.result == $past(conv_rsp.result)
                && q.state == ST_IDLE;
    endproperty
    a_done_effects: assert property (p_done_effects)
        else $error("Completion did not load result, clear run, set flag.");

    property p_flag_sticky;
        @(posedge pclk) disable iff (!presetn)
        q.done_flag && !(wr && idx == IDX_INT_STAT && pwdata[INT_DONE])
            |=> q.done_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("Done flag cleared without a software write of one.");

    property p_flag_no_sw_set;
        @(posedge pclk) disable iff (!presetn)
        !q.done_flag && !(q.state == ST_CONVERT && conv_rsp.done)
            |=> !q.done_flag;
    endproperty
    a_flag_no_sw_set: assert property (p_flag_no_sw_set)
        else $error("Done flag set without a completion.");

    property p_pin_enable_write;
        @(posedge pclk) disable iff (!presetn)
        wr && idx == IDX_PIN_EN |=> pin_analog == $past(pwdata[7:0]);
    endproperty
    a_pin_enable_write: assert property (p_pin_enable_write)
        else $error("Analog pin routing does not follow the written value.");

    property p_pin0_priority;
        @(posedge pclk) disable iff (!presetn)
        (ext_int_en |-> pin0_fn == PIN_INT)
            and (!ext_int_en && q.pin_en[0] |-> pin0_fn == PIN_ANALOG);
    endproperty
    a_pin0_priority: assert property (p_pin0_priority)
        else $error("Shared pin priority violated.");

    property p_selection_held;
        @(posedge pclk) disable iff (!presetn)
        q.state != ST_IDLE ##1 q.state != ST_IDLE
            |-> $stable(conv_cmd.channel) && $stable(conv_cmd.half_supply)
                && $stable(conv_cmd.ref_external);
    endproperty
    a_selection_held: assert property (p_selection_held)
        else $error("Selection changed during a conversion.");

    property p_capture_at_start;
        @(posedge pclk) disable iff (!presetn)
        start_req |=> conv_cmd.channel == $past(q.ctl[CTL_CHAN_LSB+:3])
            && conv_cmd.half_supply == $past(q.half_sup)
            && conv_cmd.sampling ##1 conv_cmd.sampling || !q.ctl[CTL_PWR];
    endproperty
    a_capture_at_start: assert property (p_capture_at_start)
        else $error("Channel or half-supply not captured at start.");

    property p_ref_pin_write;
        @(posedge pclk) disable iff (!presetn)
        wr && idx == IDX_CTL
            |=> reference_pin_analog == $past(pwdata[CTL_REF_SRC]);
    endproperty
    a_ref_pin_write: assert property (p_ref_pin_write)
        else $error("Reference pin use does not follow the source bit.");

    property p_power_write;
        @(posedge pclk) disable iff (!presetn)
        wr && idx == IDX_CTL |=> conv_cmd.power_on == $past(pwdata[CTL_PWR]);
    endproperty
    a_power_write: assert property (p_power_write)
        else $error("Converter power does not follow the power bit.");

    property p_go_set_by_write;
        @(posedge pclk) disable iff (!presetn)
        go_set |=> q.ctl[CTL_GO];
    endproperty
    a_go_set_by_write: assert property (p_go_set_by_write)
        else $error("Writing one to the run bit did not set it.");

    property p_flag_w1c;
        @(posedge pclk) disable iff (!presetn)
        q.done_flag && wr && idx == IDX_INT_STAT && pwdata[INT_DONE]
            && !(q.state == ST_CONVERT && conv_rsp.done) |=> !q.done_flag;
    endproperty
    a_flag_w1c: assert property (p_flag_w1c)
        else $error("Writing one did not clear the done flag.");

    property p_half_write;
        @(posedge pclk) disable iff (!presetn)
        wr && idx == IDX_CAL |=> q.half_sup == $past(pwdata[CAL_HALF]);
    endproperty
    a_half_write: assert property (p_half_write)
        else $error("Half-supply enable does not follow the written value.");

    property p_ref_level_write;
        @(posedge pclk) disable iff (!presetn)
        wr && idx == IDX_RES_LOW
            |=> q.ref_level == $past(pwdata[LOW_REF_LSB+:2]);
    endproperty
    a_ref_level_write: assert property (p_ref_level_write)
        else $error("Internal level does not follow the written value.");

    property p_result_read_only;
        @(posedge pclk) disable iff (!presetn)
        wr && idx == IDX_RES_HIGH && !(q.state == ST_CONVERT && conv_rsp.done)
            |=> $stable(q.result);
    endproperty
    a_result_read_only: assert property (p_result_read_only)
        else $error("A software write changed the conversion result.");

endmodule

`default_nettype wire

// file: adc_control_logic_tb.sv
`timescale 1ns/100ps
`default_nettype none

module adc_control_logic_tb;
    import adc_control_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, ext_int_en;
    logic [7:0]  paddr, pin_analog, latency, v, q;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, irq, reference_pin_analog, e;
    pin_fn_e     pin0_fn;
    conv_cmd_s   conv_cmd;
    conv_rsp_s   conv_rsp;
    logic [11:0] value, res;
    logic [1:0]  rate, trim, lvl;
    logic [2:0]  ch;
    logic        src, half, msk;
    int          samp_cnt, err_total, checks_done, cyc, s0;
    int          divs [4] = '{4, 1, 16, 2};
    int          sh   [4] = '{8, 4, 12, 2};

    adc_control_logic u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_int_en(ext_int_en),
        .conv_rsp(conv_rsp), .conv_cmd(conv_cmd), .pin_analog(pin_analog),
        .pin0_fn(pin0_fn), .reference_pin_analog(reference_pin_analog),
        .irq(irq)
    );

    adc_macro_model u_macro (
        .pclk(pclk), .presetn(presetn), .cmd(conv_cmd), .value(value),
        .latency(latency), .rsp(conv_rsp)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (conv_cmd.sampling === 1'b1) samp_cnt <= samp_cnt + 1;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] ad(input logic [5:0] i);
        return {i, 2'b00};
    endfunction

    task automatic chk(input string s, input logic [31:0] x,
                       input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", s, x, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        apb(1'b1, ad(i), d);
    endtask

    // Expected value holds the error response in bit 8 above the data.
    task automatic rd(input string s, input logic [7:0] a,
                      input logic [8:0] x);
        apb(1'b0, a, 8'h00);
        chk(s, {23'h000000, x}, {23'h000000, e, q});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, ext_int_en, presetn} = 5'h00;
        {paddr, pwdata, value, latency} = '0;
        {samp_cnt, err_total, checks_done, cyc} = '0;
        void'($urandom(32'h00e5));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 5; i <= 12; i++) rd("reset", ad(i[5:0]), 9'h000);
        chk("irq reset", 0, irq);
        chk("pready", 1, pready);
        $display("test reset done");
        rd("unmapped", ad(6'h0d), 9'h100);
        apb(1'b1, 8'h15, 8'hff);
        chk("misaligned", 1, e);
        rd("pin after bad", ad(IDX_PIN_EN), 9'h000);
        $display("test refusal done");
        for (int k = 0; k < 4; k++) begin
            v = 8'($urandom());
            v[0] = k[1];
            ext_int_en <= k[0];
            wr(IDX_PIN_EN, v);
            @(posedge pclk);
            chk("pin_analog", v, pin_analog);
            chk("pin0_fn", k[0] ? PIN_INT : (k[1] ? PIN_ANALOG : PIN_DIGITAL), pin0_fn);
            rd("pin_en", ad(IDX_PIN_EN), {1'b0, v});
        end
        wr(IDX_CAL, 8'hfc);
        rd("cal", ad(IDX_CAL), 9'h004);
        $display("test pins done");
        for (int i = 0; i < 16; i++) begin
            rate = i[1:0];
            trim = i[3:2];
            msk  = i[0];
            ch   = 3'($urandom());
            lvl  = 2'($urandom());
            src  = 1'($urandom());
            half = 1'($urandom());
            res  = 12'($urandom());
            value   <= res;
            latency <= 8'(20 + $urandom_range(7, 0));
            wr(IDX_TRIM, {trim, 6'h00});
            wr(IDX_RES_LOW, {2'b00, lvl, 4'h0});
            wr(IDX_CAL, {5'h00, half, 2'b00});
            wr(IDX_INT_MASK, {1'b0, msk, 6'h00});
            s0 = samp_cnt;
            wr(IDX_CTL, {src, rate, 2'b11, ch});
            wr(IDX_CTL, {src, rate, 2'b01, ~ch});
            rd("run held", ad(IDX_CTL), {1'b0, src, rate, 2'b11, ~ch});
            chk("channel", ch, conv_cmd.channel);
            chk("half", half, conv_cmd.half_supply);
            chk("ref_ext", src, conv_cmd.ref_external);
            chk("ref_pin", src, reference_pin_analog);
            chk("level", lvl, conv_cmd.ref_level);
            chk("power", 1, conv_cmd.power_on);
            while (conv_rsp.done !== 1'b1) begin
                @(posedge pclk);
            end
            repeat (2) @(posedge pclk);
            chk("sample len", sh[trim] * divs[rate], samp_cnt - s0);
            rd("run clear", ad(IDX_CTL), {1'b0, src, rate, 2'b01, ~ch});
            rd("high", ad(IDX_RES_HIGH), {1'b0, res[11:4]});
            rd("low", ad(IDX_RES_LOW), {3'b000, lvl, res[3:0]});
            rd("flag", ad(IDX_INT_STAT), 9'h040);
            chk("irq", msk, irq);
            wr(IDX_RES_HIGH, ~res[11:4]);
            rd("high ro", ad(IDX_RES_HIGH), {1'b0, res[11:4]});
            wr(IDX_INT_STAT, 8'h40);
            wr(IDX_INT_STAT, 8'h40);
            rd("flag clear", ad(IDX_INT_STAT), 9'h000);
            chk("irq clear", 0, irq);
            wr(IDX_CTL, 8'h00);
            @(posedge pclk);
            chk("power off", 0, conv_cmd.power_on);
            chk("ref pin off", 0, reference_pin_analog);
            $display("test conversion %0d done", i);
        end
        results();
    end

endmodule

`default_nettype wire

// file: adc_control_pkg.sv
package adc_control_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam int unsigned APB_AW        = 8;
    localparam logic [5:0]  IDX_PIN_EN    = 6'h05;
    localparam logic [5:0]  IDX_CTL       = 6'h06;
    localparam logic [5:0]  IDX_CAL       = 6'h07;
    localparam logic [5:0]  IDX_RES_HIGH  = 6'h08;
    localparam logic [5:0]  IDX_RES_LOW   = 6'h09;
    localparam logic [5:0]  IDX_TRIM      = 6'h0a;
    localparam logic [5:0]  IDX_INT_STAT  = 6'h0b;
    localparam logic [5:0]  IDX_INT_MASK  = 6'h0c;

    ////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned CTL_REF_SRC   = 7;
    localparam int unsigned CTL_RATE_LSB  = 5;
    localparam int unsigned CTL_GO        = 4;
    localparam int unsigned CTL_PWR       = 3;
    localparam int unsigned CTL_CHAN_LSB  = 0;
    localparam int unsigned CAL_HALF      = 2;
    localparam int unsigned LOW_REF_LSB   = 4;
    localparam int unsigned TRIM_LSB      = 6;
    localparam int unsigned INT_DONE      = 6;

    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0]  PIN_EN_RST    = 8'h00;
    localparam logic [7:0]  CTL_RST       = 8'h00;
    localparam logic [1:0]  REF_LEVEL_RST = 2'h0;
    localparam logic [1:0]  TRIM_RST      = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock codes and divider terminal counts.
    localparam logic [1:0]  RATE_DIV4     = 2'h0;
    localparam logic [1:0]  RATE_DIV1     = 2'h1;
    localparam logic [1:0]  RATE_DIV16    = 2'h2;
    localparam logic [1:0]  RATE_DIV2     = 2'h3;
    localparam logic [3:0]  TERM_DIV4     = 4'h3;
    localparam logic [3:0]  TERM_DIV1     = 4'h0;
    localparam logic [3:0]  TERM_DIV16    = 4'hf;
    localparam logic [3:0]  TERM_DIV2     = 4'h1;

    // Sample-and-hold lengths in converter clock periods per trim code.
    localparam logic [1:0]  TRIM_00       = 2'h0;
    localparam logic [1:0]  TRIM_01       = 2'h1;
    localparam logic [1:0]  TRIM_10       = 2'h2;
    localparam logic [3:0]  SH_TRIM_00    = 4'h8;
    localparam logic [3:0]  SH_TRIM_01    = 4'h4;
    localparam logic [3:0]  SH_TRIM_10    = 4'hc;
    localparam logic [3:0]  SH_TRIM_11    = 4'h2;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_e;

    typedef enum logic [1:0] {
        PIN_DIGITAL = 2'b00,
        PIN_ANALOG  = 2'b01,
        PIN_INT     = 2'b10
    } pin_fn_e;

    typedef struct packed {
        logic       power_on;
        logic       start;
        logic       sampling;
        logic       ref_external;
        logic [1:0] ref_level;
        logic       half_supply;
        logic [2:0] channel;
        logic       tad_tick;
    } conv_cmd_s;

    typedef struct packed {
        logic        done;
        logic [11:0] result;
    } conv_rsp_s;

    typedef struct packed {
        logic [3:0] div_cnt;
        logic [3:0] sh_cnt;
        logic       tick;
        logic       busy;
    } tad_state_s;

    typedef struct packed {
        conv_state_e state;
        logic [7:0]  pin_en;
        logic [7:0]  ctl;
        logic        half_sup;
        logic [1:0]  ref_level;
        logic [1:0]  trim;
        logic [11:0] result;
        logic        done_flag;
        logic        done_mask;
        logic        cap_ref_ext;
        logic [1:0]  cap_ref_level;
        logic        cap_half;
        logic [2:0]  cap_channel;
        logic        conv_start;
        logic [31:0] prdata;
    } ctl_state_s;

    localparam ctl_state_s CTL_STATE_RST = '{
        state:     ST_IDLE,
        pin_en:    PIN_EN_RST,
        ctl:       CTL_RST,
        ref_level: REF_LEVEL_RST,
        trim:      TRIM_RST,
        default:   '0
    };

endpackage

// file: adc_macro_model.sv
`timescale 1ns/100ps
`default_nettype none

// Converter macro stand-in: answers each start pulse after a set latency.
module adc_macro_model (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire adc_control_pkg::conv_cmd_s  cmd,
    input  wire logic [11:0]                 value,
    input  wire logic [7:0]                  latency,
    output var  adc_control_pkg::conv_rsp_s  rsp
);
    import adc_control_pkg::*;

    logic       busy;
    logic [7:0] cnt;

    ////////////////////////////////////////////////////////////////////////
    // The result lines toggle outside the done cycle so stale data shows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt  <= 8'h00;
            rsp  <= '0;
        end else begin
            if (cmd.start && cmd.power_on) begin
                busy       <= 1'b1;
                cnt        <= latency;
                rsp.done   <= 1'b0;
                rsp.result <= ~rsp.result;
            end else if (busy && cnt == 8'h00) begin
                busy       <= 1'b0;
                rsp.done   <= 1'b1;
                rsp.result <= value;
            end else begin
                if (busy) begin
                    cnt <= cnt - 8'h01;
                end
                rsp.done   <= 1'b0;
                rsp.result <= ~rsp.result;
            end
        end
    end

endmodule

`default_nettype wire

// file: adc_tad_gen.sv
`timescale 1ns/100ps
`default_nettype none

module adc_tad_gen (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [1:0] rate,
    input  wire logic [1:0] trim,
    input  wire logic       start,
    output logic            tad_tick,
    output logic            sample_busy
);
    import adc_control_pkg::*;

    tad_state_s q;
    tad_state_s d;
    logic [3:0] term;
    logic [3:0] sh_len;
    logic       wrap;

    ////////////////////////////////////////////////////////////////////////
    // Divider terminal count and sample length selection.
    always_comb begin
        case (rate)
            RATE_DIV4:  term = TERM_DIV4;
            RATE_DIV1:  term = TERM_DIV1;
            RATE_DIV16: term = TERM_DIV16;
            default:    term = TERM_DIV2;
        endcase
        case (trim)
            TRIM_00: sh_len = SH_TRIM_00;
            TRIM_01: sh_len = SH_TRIM_01;
            TRIM_10: sh_len = SH_TRIM_10;
            default: sh_len = SH_TRIM_11;
        endcase
    end

    // Each wrap of the divider ends one converter clock period.
    assign wrap = run && q.div_cnt >= term;

    always_comb begin
        d = q;
        d.tick = wrap;
        if (!run || start || wrap) begin
            d.div_cnt = '0;
        end else begin
            d.div_cnt = q.div_cnt + 4'h1;
        end
        if (start) begin
            d.busy = 1'b1;
            d.sh_cnt = sh_len;
        end else if (q.busy && wrap) begin
            d.sh_cnt = q.sh_cnt - 4'h1;
            d.busy = (q.sh_cnt != 4'h1);
        end
        if (!run) begin
            d.busy = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tad_tick = q.tick;
    // Drops in the last period so the sequencer leaves after exactly N periods.
    assign sample_busy = q.busy && !(wrap && q.sh_cnt == 4'h1);

    ////////////////////////////////////////////////////////////////////////
    property p_div1_every_cycle;
        @(posedge pclk) disable iff (!presetn)
        run && rate == RATE_DIV1 ##1 run && rate == RATE_DIV1 |-> tad_tick;
    endproperty
    a_div1_every_cycle: assert property (p_div1_every_cycle)
        else $error("Divide-by-one clock did not tick every cycle.");

    property p_sample_len_00;
        @(posedge pclk) disable iff (!presetn)
        start && rate == RATE_DIV1 && trim == TRIM_00
            ##1 (run && rate == RATE_DIV1 && !start)[*8]
            |-> !sample_busy && $past(sample_busy) && $past(sample_busy, 7);
    endproperty
    a_sample_len_00: assert property (p_sample_len_00)
        else $error("Sample phase was not eight converter clocks.");

endmodule

`default_nettype wire
